//--- design/lrlr_pkg.sv
/*
 * lrlr_pkg: constants and carrier types for the link reset and lock
 * recovery controller. Assumes a 40 MHz core clock.
 */
package lrlr_pkg;
    // core clock rate
    localparam int unsigned CLK_HZ = 40_000_000;
    // power-down pin low time, least, in microseconds
    localparam int unsigned PIN_LOW_MIN_US = 2000;
    localparam int unsigned PIN_LOW_MIN_CYC = (PIN_LOW_MIN_US * (CLK_HZ / 1_000_000));
    // data lock time after pin release, typical and most, in microseconds
    localparam int unsigned LOCK_TYP_US = 15000;
    localparam int unsigned LOCK_MAX_US = 22000;
    localparam int unsigned LOCK_TYP_CYC = (LOCK_TYP_US * (CLK_HZ / 1_000_000));
    localparam int unsigned LOCK_MAX_CYC = (LOCK_MAX_US * (CLK_HZ / 1_000_000));
    // adaptive equalizer step interval in core clocks
    localparam int unsigned ACQ_STEP_CYC_DEF = 4096;
    // register offsets and field positions
    localparam logic [7:0] REG_RESET_OFS = 8'h01;
    localparam int unsigned DIG_RESET_BIT = 1;
    localparam logic [7:0] REG_MANUAL_EQ_OFS = 8'h04;
    localparam logic [7:0] REG_EQ_TEST_OFS = 8'h4d;
    localparam int unsigned EQ_BYPASS_BIT = 6;
    localparam logic [7:0] REG_EQ_VALUE_OFS = 8'h4e;
    localparam int unsigned EQ_READBACK_LSB = 4;
    // equalizer level width and reset level
    localparam int unsigned EQ_W = 4;
    localparam logic [3:0] EQ_RESET_LEVEL = 4'h0;
    // lock acquisition states
    typedef enum logic [1:0] {
        LRLR_OFF,
        LRLR_ACQUIRE,
        LRLR_LOCKED
    } lrlr_state_t;
    // equalizer settings that travel together
    typedef struct packed {
        logic bypass;
        logic [3:0] manual_level;
    } lrlr_eq_cfg_t;
endpackage

//--- design/lrlr_eq_adapt.sv
/*
 * lrlr_eq_adapt: adaptive equalizer level stepper. Steps the level on each
 * step enable while the eye is poor; cleared by restart.
 * Assumes all inputs are on CLOCK_I's domain.
 */
`timescale 1ns/1ps
`default_nettype none
module lrlr_eq_adapt
    import lrlr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic restart_i,
    input wire logic step_i,
    input wire logic eye_poor_i,
    output logic [3:0] level_o
);
    typedef struct packed {
        logic [3:0] level;
    } lrlr_adapt_t;
    lrlr_adapt_t st, next_st;

    // thermometer step keeps the level on the five-code ladder
    always_comb
    begin
        next_st = st;
        if (restart_i)
        begin
            next_st.level = EQ_RESET_LEVEL;
        end
        else if (step_i && eye_poor_i)
        begin
            next_st.level = {st.level[2:0], 1'b1};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            st <= '{level: EQ_RESET_LEVEL};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign level_o = st.level;
endmodule
`default_nettype wire

//--- design/lrlr_top.sv
/*
 * lrlr_top: reset and lock recovery controller for a serial video link
 * receiver. Holds the config bits as ports, sequences lock acquisition.
 * Assumes pin inputs are asynchronous; config and reset-bit writes come
 * from a register decoder on CLOCK_I.
 */
// Behaviour
// RQ1: reset by power-down pin or by writing one to digital reset bit.
// RQ2: digital reset restarts all logic but keeps configuration values.
// RQ3: digital reset bit clears itself once the reset has run.
// RQ4: host resets the device with signal present after wrong bring-up.
// RQ5: host resets the device when lock drops after cable replug.
// RQ6: host holds power-down pin low at least 2 ms.
// RQ7: lock achieved within 22 ms of power-down pin rising.
// RQ8: on lock loss, equalizer resets and acquisition reruns until locked.
// RQ9: equalization level may be set manually.
// RQ10: equalized level is presented on the monitor output.
// RQ11: bypass bit selects manual level instead of adaptive equalizer.
// RQ12: level in use is reported in read-back bits 7 to 4.
// RQ13: lock indicator low during any reset or reacquisition.
`timescale 1ns/1ps
`default_nettype none
module lrlr_top
    import lrlr_pkg::*;
#(
    parameter int unsigned LOCK_TIMEOUT_CYC = LOCK_MAX_CYC,
    parameter int unsigned ACQ_STEP_CYC = ACQ_STEP_CYC_DEF
)
(
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic POWER_DOWN_RESET_PIN_N_I,
    input wire logic DIG_RESET_WR_I,
    input wire logic EQ_BYPASS_I,
    input wire logic [3:0] MANUAL_EQ_LEVEL_I,
    input wire logic SIGNAL_DETECT_I,
    input wire logic PHASE_LOCK_I,
    input wire logic EYE_POOR_I,
    output logic DIG_RESET_BIT_O,
    output logic LOCK_O,
    output logic LOCK_TIMEOUT_O,
    output logic [7:0] EQ_VALUE_REG_O,
    output logic [3:0] EQ_MONITOR_LEVEL_O
);
    // refuse timing the counters cannot serve: a zero step never pulses,
    // and a step longer than the lock window would move the level one step at most
    if (LOCK_TIMEOUT_CYC < 1)
    begin : g_bad_timeout
        $error("lrlr_top: LOCK_TIMEOUT_CYC must be at least one");
    end
    if (ACQ_STEP_CYC < 1 || ACQ_STEP_CYC > LOCK_TIMEOUT_CYC)
    begin : g_bad_step
        $error("lrlr_top: ACQ_STEP_CYC must lie between one and LOCK_TIMEOUT_CYC");
    end
    // the level ladder is four thermometer bits wide
    if (EQ_W != 4)
    begin : g_bad_eq_width
        $error("lrlr_top: EQ_W must be four");
    end

    typedef struct packed {
        logic [1:0] pdn_sync;
        logic [1:0] sd_sync;
        logic [1:0] pl_sync;
        logic [1:0] eye_sync;
        logic dig_reset;
        lrlr_state_t state;
        logic [31:0] timer;
        logic [31:0] step_cnt;
        logic timeout;
        logic lock;
        logic [7:0] eq_value;
        logic [3:0] mon_level;
    } lrlr_state_all_t;

    // reset image: synchronisers empty, acquisition idle, level at the bottom
    localparam lrlr_state_all_t ST_RESET = '{
        pdn_sync: 2'b00,
        sd_sync: 2'b00,
        pl_sync: 2'b00,
        eye_sync: 2'b00,
        dig_reset: 1'b0,
        state: LRLR_OFF,
        timer: 32'h0,
        step_cnt: 32'h0,
        timeout: 1'b0,
        lock: 1'b0,
        eq_value: {EQ_RESET_LEVEL, 4'h0},
        mon_level: EQ_RESET_LEVEL
    };

    // two-flop shift: bit 0 meets the pin, only bit 1 feeds any logic
    function automatic logic [1:0] sync2(input logic [1:0] chain, input logic pin);
        return {chain[0], pin};
    endfunction

    // lock is declared only while phase lock and a signal are both present
    function automatic logic link_good(input lrlr_state_all_t s);
        return s.pl_sync[1] && s.sd_sync[1];
    endfunction

    lrlr_state_all_t st, next_st;
    logic [3:0] adapt_level;
    logic [3:0] used_level;
    logic restart_eq;
    logic any_reset;
    logic step_pulse;
    logic pin_low;
    lrlr_eq_cfg_t eq_cfg;

    // config bits kept in the outer register file, so no reset reaches them
    assign eq_cfg = '{bypass: EQ_BYPASS_I, manual_level: MANUAL_EQ_LEVEL_I};
    assign pin_low = !st.pdn_sync[1];
    // pin or register-bit reset, either one restarts the logic
    assign any_reset = pin_low || st.dig_reset; // RQ1
    // equalizer restarts on any reset and on every fresh acquisition;
    // it is not restarted while locked, but still steps up while the eye is poor
    assign restart_eq = any_reset || (st.state == LRLR_OFF); // RQ8
    // divider, cleared on any reset: one-cycle step enable every ACQ_STEP_CYC clocks
    assign step_pulse = (st.step_cnt == ACQ_STEP_CYC - 1);
    // level in use: manual when bypassed, adaptive otherwise
    assign used_level = eq_cfg.bypass ? eq_cfg.manual_level : adapt_level; // RQ9 RQ11

    lrlr_eq_adapt u_eq
    (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .restart_i(restart_eq),
        .step_i(step_pulse),
        .eye_poor_i(st.eye_sync[1]),
        .level_o(adapt_level)
    );

    // next-state logic: every output is a register fed from here, so the
    // pins never see glitches from the decode
    always_comb
    begin
        next_st = st;
        // two-stage synchronisers for pin-side inputs
        next_st.pdn_sync = sync2(st.pdn_sync, POWER_DOWN_RESET_PIN_N_I);
        next_st.sd_sync = sync2(st.sd_sync, SIGNAL_DETECT_I);
        next_st.pl_sync = sync2(st.pl_sync, PHASE_LOCK_I);
        next_st.eye_sync = sync2(st.eye_sync, EYE_POOR_I);
        // self-clearing reset bit: set is one-cycle, runs one restart, then clears
        next_st.dig_reset = 1'b0; // RQ3
        if (DIG_RESET_WR_I)
        begin
            next_st.dig_reset = 1'b1; // RQ1
        end
        next_st.step_cnt = step_pulse ? 32'h0 : st.step_cnt + 32'h1;
        next_st.eq_value = {used_level, 4'h0}; // RQ12
        next_st.mon_level = used_level; // RQ10
        if (any_reset)
        begin
            // pin or bit reset: logic restarts, config ports untouched
            next_st.state = LRLR_OFF; // RQ1 RQ2
            next_st.lock = 1'b0; // RQ13
            next_st.timer = 32'h0;
            next_st.timeout = 1'b0;
            next_st.step_cnt = 32'h0;
        end
        else
        begin
            unique case (st.state)
                LRLR_OFF:
                begin
                    next_st.state = LRLR_ACQUIRE;
                    next_st.timer = 32'h0;
                    next_st.lock = 1'b0;
                end
                LRLR_ACQUIRE:
                begin
                    // lock declared on phase lock with signal present
                    if (link_good(st))
                    begin
                        next_st.state = LRLR_LOCKED;
                        next_st.lock = 1'b1; // RQ13
                    end
                    else if (st.timer == LOCK_TIMEOUT_CYC - 1)
                    begin
                        // missed the lock window: flag it, restart acquisition
                        // the flag stays up until the next pin or bit reset
                        next_st.timeout = 1'b1; // RQ7
                        next_st.state = LRLR_OFF;
                    end
                    else
                    begin
                        next_st.timer = st.timer + 32'h1;
                    end
                end
                LRLR_LOCKED:
                begin
                    // while locked the equalizer is not restarted, but still steps on a poor eye
                    if (!link_good(st))
                    begin
                        // lost lock: equalizer resets via restart_eq, acquire again
                        next_st.state = LRLR_OFF; // RQ8
                        next_st.lock = 1'b0; // RQ13
                    end
                end
            endcase
        end
    end

    // synchronous reset to the reset image; config ports hold no state here
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            st <= ST_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign DIG_RESET_BIT_O = st.dig_reset;
    assign LOCK_O = st.lock;
    assign LOCK_TIMEOUT_O = st.timeout;
    assign EQ_VALUE_REG_O = st.eq_value;
    assign EQ_MONITOR_LEVEL_O = st.mon_level;
endmodule
`default_nettype wire

//--- testbench/lrlr_monitor.sv
/* lrlr_monitor: port assertions for lrlr_top.
   Assumes it is bound to every lrlr_top instance. */
`timescale 1ns/1ps
`default_nettype none
module lrlr_monitor
    import lrlr_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic POWER_DOWN_RESET_PIN_N_I,
    input wire logic DIG_RESET_WR_I,
    input wire logic EQ_BYPASS_I,
    input wire logic [3:0] MANUAL_EQ_LEVEL_I,
    input wire logic SIGNAL_DETECT_I,
    input wire logic PHASE_LOCK_I,
    input wire logic DIG_RESET_BIT_O,
    input wire logic LOCK_O,
    input wire logic [7:0] EQ_VALUE_REG_O,
    input wire logic [3:0] EQ_MONITOR_LEVEL_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    // lock figures allow for the two sync flops on the pins
    chk_bit_set: assert property (DIG_RESET_WR_I |=> DIG_RESET_BIT_O)
        else $error("reset bit not set");
    chk_bit_clears: assert property (DIG_RESET_BIT_O && !DIG_RESET_WR_I |=> !DIG_RESET_BIT_O)
        else $error("reset bit stuck");
    chk_reset_unlock: assert property (DIG_RESET_BIT_O |=> !LOCK_O)
        else $error("lock kept in reset");
    chk_pin_unlock: assert property (!POWER_DOWN_RESET_PIN_N_I [*4] |-> !LOCK_O)
        else $error("lock kept with pin low");
    chk_lock_prompt: assert property ((POWER_DOWN_RESET_PIN_N_I
        && SIGNAL_DETECT_I && PHASE_LOCK_I && !DIG_RESET_WR_I && !DIG_RESET_BIT_O) [*8]
        |-> ##[0:4] LOCK_O)
        else $error("lock late");
    chk_lock_loss: assert property (!PHASE_LOCK_I [*5] |-> !LOCK_O)
        else $error("lock without phase");
    chk_bypass_level: assert property ((EQ_BYPASS_I
        && $stable(MANUAL_EQ_LEVEL_I)) [*3] |-> EQ_MONITOR_LEVEL_O == MANUAL_EQ_LEVEL_I)
        else $error("manual level not used");
    chk_readback_map: assert property (1'b1 |-> EQ_VALUE_REG_O == {EQ_MONITOR_LEVEL_O, 4'h0})
        else $error("readback mismatch");
    chk_readback_manual: assert property (EQ_BYPASS_I |=> EQ_VALUE_REG_O
        == {$past(MANUAL_EQ_LEVEL_I), 4'h0})
        else $error("readback not the manual level");
    chk_eq_restart: assert property (($fell(LOCK_O) && !EQ_BYPASS_I)
        ##1 !EQ_BYPASS_I |=> EQ_MONITOR_LEVEL_O == EQ_RESET_LEVEL)
        else $error("equalizer not restarted on lock loss");
endmodule
bind lrlr_top lrlr_monitor u_mon (.*);
`default_nettype wire

//--- testbench/lrlr_link_model.sv
/* lrlr_link_model: far end of the serial link as seen by the receiver.
   Assumes knobs change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module lrlr_link_model
(
    input wire logic clk_i,
    input wire logic present_i,
    input wire logic locked_i,
    input wire logic poor_i,
    output var logic sig_detect_o,
    output var logic phase_lock_o,
    output var logic eye_poor_o
);
    // knobs set at the falling edge land at the next rising edge by
    // non-blocking update, so the receiver never races them;
    // phase lock needs a signal, and an unplug drops both at once
    always_ff @(posedge clk_i)
    begin
        sig_detect_o <= present_i;
        phase_lock_o <= present_i && locked_i;
        eye_poor_o <= poor_i;
    end
endmodule
`default_nettype wire

//--- testbench/tb.sv
/* tb: directed bench for lrlr_top with a link model.
   Assumes short timeout and step parameters. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lrlr_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, pin_n = 1'b1, wr = 1'b0, byp = 1'b0;
    logic present = 1'b1, locked = 1'b1, poor = 1'b0;
    logic sd, pl, eye, bit_o, lock, tmo;
    logic [3:0] man = 4'h5, eqm;
    logic [7:0] eqv;
    int fails = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    lrlr_link_model u_link (.clk_i(clk), .present_i(present), .locked_i(locked),
        .poor_i(poor), .sig_detect_o(sd), .phase_lock_o(pl), .eye_poor_o(eye));
    lrlr_top #(.LOCK_TIMEOUT_CYC(200), .ACQ_STEP_CYC(8)) DUT (.CLOCK_I(clk), .RST_N_I(rst_n),
        .POWER_DOWN_RESET_PIN_N_I(pin_n), .DIG_RESET_WR_I(wr), .EQ_BYPASS_I(byp),
        .MANUAL_EQ_LEVEL_I(man), .SIGNAL_DETECT_I(sd), .PHASE_LOCK_I(pl), .EYE_POOR_I(eye),
        .DIG_RESET_BIT_O(bit_o), .LOCK_O(lock), .LOCK_TIMEOUT_O(tmo),
        .EQ_VALUE_REG_O(eqv), .EQ_MONITOR_LEVEL_O(eqm));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait, so a dead link shows as a mismatch, not a hang
    task automatic wait_lock();
        for (int i = 0; i < 40 && lock !== 1'b1; i++) @(negedge clk);
        check("lock", {7'h0, lock}, 8'h01);
    endtask
    task automatic pulse();
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask
    task automatic t_pin();
        wait_lock();
        pin_n = 1'b0;
        cyc(PIN_LOW_MIN_CYC);
        check("lock in pin reset", {7'h0, lock}, 8'h00);
        pin_n = 1'b1;
        wait_lock();
    endtask
    task automatic t_dig();
        byp = 1'b1;
        man = 4'ha;
        cyc(4);
        pulse();
        check("reset bit", {7'h0, bit_o}, 8'h01);
        cyc(1);
        check("bit clears", {7'h0, bit_o}, 8'h00);
        check("lock drops", {7'h0, lock}, 8'h00);
        wait_lock();
        check("manual kept", {4'h0, eqm}, 8'h0a);
        check("readback", eqv, 8'ha0);
    endtask
    task automatic t_adapt();
        byp = 1'b0;
        locked = 1'b0;
        poor = 1'b1;
        cyc(100);
        check("adaptive top", {4'h0, eqm}, 8'h0f);
        locked = 1'b1;
        poor = 1'b0;
        wait_lock();
        check("eq held locked", {4'h0, eqm}, 8'h0f);
        present = 1'b0;
        cyc(8);
        check("lock lost", {7'h0, lock}, 8'h00);
        check("eq restarted", {4'h0, eqm}, 8'h00);
        present = 1'b1;
        pulse();
        wait_lock();
    endtask
    task automatic t_tmo();
        present = 1'b0;
        cyc(220);
        check("timeout", {7'h0, tmo}, 8'h01);
        present = 1'b1;
        pulse();
        wait_lock();
        check("timeout cleared", {7'h0, tmo}, 8'h00);
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        cyc(4);
        rst_n = 1'b1;
        t_pin();
        t_dig();
        t_adapt();
        t_tmo();
        conclude();
    end
    // watchdog sized a little past the pin reset span
    initial
    begin
        #(25 * 95000);
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
